// *** include/stt_pkg.sv ***
package stt_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned NOTRIG_MS = 2000;
  localparam int unsigned NOTRIG_CYC = CLK_HZ / 1000 * NOTRIG_MS;
  localparam int unsigned KNOB_FAST_US = 20000;
  localparam int unsigned KNOB_FAST_CYC = CLK_HZ / 1_000_000 * KNOB_FAST_US;
  localparam int unsigned STRAP_WAIT = 3;

  // ==========================================================
  // delay, in steps of 1/500 record (0.2 % pretrigger or 0.02 div)
  localparam int PRE_MAX_STEPS = 500;
  localparam int POST_MAX_STEPS = 500000;
  localparam int STEPS_PER_RECORD = 500;
  localparam int TENTH_PCT_PER_STEP = 2;
  localparam int PS_PER_STEP_NS = 20;
  localparam int DLY_FINE = 1;
  localparam int DLY_COARSE = 25;

  // ==========================================================
  // level limits
  localparam int LVL_DIVS = 5;
  localparam int EXT_LVL_LIM = 200;
  localparam int LVL_ABS_MAX = 32767;
  localparam int LVL_STEP = 1;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SRC_CH1 = 2'h0,
    SRC_CH2 = 2'h1,
    SRC_CH4 = 2'h2,
    SRC_LINE = 2'h3
  } stt_src_t;

  typedef enum logic [2:0] {
    high_freq_coupling = 3'h0,
    ac_coupling = 3'h1,
    low_freq_reject_coupling = 3'h2,
    high_freq_reject_coupling = 3'h3,
    dc_coupling = 3'h4
  } stt_coup_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'h0,
    ST_FILL = 2'h1,
    ST_READY = 2'h2,
    ST_POST = 2'h3
  } stt_acq_t;

  typedef enum logic {
    MODE_SINGLE = 1'h0,
    MODE_NORMAL = 1'h1
  } stt_mode_t;

  // ==========================================================
  // reset values
  localparam stt_src_t RST_SRC = SRC_CH1;
  localparam stt_coup_t RST_COUP = dc_coupling;
  localparam logic RST_SLOPE_RISE = 1'h1;
  localparam stt_mode_t RST_MODE = MODE_NORMAL;
  localparam stt_acq_t RST_ACQ = ST_FILL;

endpackage

// *** rtl/stt_sync.sv ***
`timescale 1ns/1ps
module stt_sync import stt_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // ==========================================================
  // two stages; first stage feeds only the second
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule // stt_sync

// *** rtl/stt_acq_ram.sv ***
`timescale 1ns/1ps
module stt_acq_ram import stt_pkg::*; #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port, registered
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // ==========================================================
  // storage, no reset so it maps to block ram
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // stt_acq_ram

// *** rtl/stt_ctrl.sv ***
`timescale 1ns/1ps
module stt_ctrl import stt_pkg::*; #(
  parameter int AW = 10,
  parameter int DW = 8,
  parameter int unsigned NOTRIG_CYCLES = NOTRIG_CYC,
  parameter int unsigned KNOB_FAST_CYCLES = KNOB_FAST_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // front panel, asynchronous
  input wire logic [3:0] src_btn,
  input wire logic [4:0] coup_btn,
  input wire logic slope_btn,
  input wire logic zero_btn,
  input wire logic single_btn,
  input wire logic norm_btn,
  input wire logic adv_btn,
  input wire logic dly_knob_step,
  input wire logic dly_knob_dir,
  input wire logic lvl_knob_step,
  input wire logic lvl_knob_dir,
  input wire logic ext_fitted,
  // trigger comparators, asynchronous
  input wire logic [2:0] trig_cmp,
  input wire logic line_zero_cross,
  // acquisition context, same clock
  input wire logic no_hf_mode,
  input wire logic ris_mode,
  input wire logic roll_mode,
  input wire logic ris_done,
  input wire logic [31:0] tdiv_ns,
  input wire logic [15:0] sel_vdiv_mv,
  input wire logic adc_valid,
  input wire logic [DW-1:0] adc_data,
  input wire logic [AW-1:0] rd_addr,
  // trigger setup
  output logic [1:0] sel_src,
  output logic [2:0] coupling,
  output logic slope_rising,
  output logic [15:0] trig_level,
  output logic ext_note,
  output logic adv_led,
  // delay display
  output logic [9:0] pretrig_tenth_pct,
  output logic [63:0] post_delay_ps,
  // acquisition status
  output logic ready_led,
  output logic trigd_led,
  output logic record_done,
  output logic [AW-1:0] trig_addr,
  output logic partial_recon,
  output logic frozen,
  output logic no_trig_warn,
  output logic [DW-1:0] rd_data
);

  localparam int DEPTH = 1 << AW;
  localparam int SW = 23;

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] strap_cnt;
    logic rear_external_source;
    logic [15:0] btn_prev;
    logic [3:0] cmp_prev;
    stt_src_t src;
    stt_coup_t [3:0] coup;
    logic [3:0] slope_rise;
    logic [3:0][15:0] lvl;
    logic adv;
    logic signed [19:0] delay;
    logic [18:0] knob_gap;
    stt_mode_t mode;
    stt_acq_t acq;
    logic [AW-1:0] wptr;
    logic [AW:0] fill_cnt;
    logic [33:0] post_cnt;
    logic [AW-1:0] trig_addr;
    logic trigd;
    logic done;
    logic partial;
    logic ris_got;
    logic frozen;
    logic [25:0] notrig_cnt;
    logic warn;
    logic ext_note;
    logic [2:0] coup_out;
    logic slope_out;
    logic [15:0] lvl_out;
    logic [9:0] pre_pct;
    logic [63:0] post_ps;
    logic ready;
  } stt_state_t;

  stt_state_t s_q;
  stt_state_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [SW-1:0] pins_s;
  logic [15:0] btn_now;
  logic [15:0] btn_rise;
  logic [3:0] cmp_now;
  logic fire;
  logic ram_we;

  // ==========================================================
  // reset release and pin synchronisers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  stt_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({ext_fitted, line_zero_cross, trig_cmp, lvl_knob_dir, lvl_knob_step, dly_knob_dir,
          dly_knob_step, adv_btn, norm_btn, single_btn, zero_btn, slope_btn, coup_btn, src_btn}),
    .dout(pins_s)
  );

  // bits: 3:0 source, 8:4 coupling, 9 slope, 10 zero, 11 single, 12 norm,
  // 13 adv, 14 delay step, 15 level step
  assign btn_now = {pins_s[16], pins_s[14], pins_s[13:0]};
  assign btn_rise = btn_now & ~s_q.btn_prev;
  assign cmp_now = {pins_s[21], pins_s[20:18]};

  // ==========================================================
  // circular acquisition buffer
  assign ram_we = adc_valid && (s_q.acq != ST_HOLD);

  stt_acq_ram #(.AW(AW), .DW(DW)) u_ram (
    .clk(clk),
    .we(ram_we),
    .waddr(s_q.wptr),
    .wdata(adc_data),
    .raddr(rd_addr),
    .rdata(rd_data)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic signed [39:0] dtmp;
    logic signed [39:0] lim;
    logic signed [39:0] ltmp;
    logic [39:0] pre_samp;
    logic [39:0] rem;
    logic [1:0] si;
    logic hf_eff;
    logic cur;
    logic prv;
    dtmp = '0;
    lim = '0;
    ltmp = '0;
    pre_samp = '0;
    rem = '0;
    si = '0;
    hf_eff = 1'b0;
    cur = 1'b0;
    prv = 1'b0;
    fire = 1'b0;
    s_d = s_q;
    s_d.btn_prev = btn_now;
    s_d.cmp_prev = cmp_now;
    s_d.done = 1'b0;
    s_d.ext_note = 1'b0;

    // strap sampled once the synchroniser has filled
    if (s_q.strap_cnt != 2'(STRAP_WAIT)) begin
      s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      if (s_q.strap_cnt == 2'(STRAP_WAIT - 1)) begin
        s_d.rear_external_source = pins_s[22];
      end
    end

    // source select; lowest button wins
    for (int i = 3; i >= 0; i--) begin
      if (btn_rise[i]) begin
        s_d.src = stt_src_t'(2'(i));
      end
    end
    if (s_d.src == SRC_CH4 && s_q.src != SRC_CH4 && s_q.rear_external_source) begin
      s_d.ext_note = 1'b1;
    end
    si = s_d.src;

    // coupling, stored per source
    for (int i = 4; i >= 0; i--) begin
      if (btn_rise[4+i]) begin
        s_d.coup[si] = stt_coup_t'(3'(i));
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (no_hf_mode && s_d.coup[i] == high_freq_coupling) begin
        s_d.coup[i] = dc_coupling;
      end
    end
    hf_eff = (s_d.coup[si] == high_freq_coupling);

    // slope per source, rising only under high-freq coupling
    if (btn_rise[9] && !hf_eff) begin
      s_d.slope_rise[si] = ~s_q.slope_rise[si];
    end
    if (hf_eff) begin
      s_d.slope_rise[si] = 1'b1;
    end

    // advanced control toggle
    if (btn_rise[13]) begin
      s_d.adv = ~s_q.adv;
    end

    // delay knob with speed scaling; one value for all sources
    if (s_q.knob_gap != 19'(KNOB_FAST_CYCLES)) begin
      s_d.knob_gap = s_q.knob_gap + 19'h1;
    end
    if (btn_rise[14]) begin
      s_d.knob_gap = '0;
      dtmp = (s_q.knob_gap < 19'(KNOB_FAST_CYCLES)) ? 40'(DLY_COARSE) : 40'(DLY_FINE);
      dtmp = pins_s[15] ? 40'(s_q.delay) + dtmp : 40'(s_q.delay) - dtmp;
      if (dtmp > 40'(POST_MAX_STEPS)) begin
        dtmp = 40'(POST_MAX_STEPS);
      end
      if (dtmp < -40'(PRE_MAX_STEPS)) begin
        dtmp = -40'(PRE_MAX_STEPS);
      end
      s_d.delay = 20'(dtmp);
    end
    if (btn_rise[10]) begin
      s_d.delay = '0;
    end

    // level knob; limit only applied on a turn so gain changes keep volts
    if (s_d.src == SRC_LINE) begin
      lim = '0;
    end else if (s_d.src == SRC_CH4 && s_q.rear_external_source) begin
      lim = 40'(EXT_LVL_LIM);
    end else begin
      lim = 40'(sel_vdiv_mv) * 40'(LVL_DIVS);
      if (lim > 40'(LVL_ABS_MAX)) begin
        lim = 40'(LVL_ABS_MAX);
      end
    end
    if (btn_rise[15] && s_d.src != SRC_LINE) begin
      ltmp = 40'($signed(s_q.lvl[si]));
      ltmp = pins_s[17] ? ltmp + 40'(LVL_STEP) : ltmp - 40'(LVL_STEP);
      if (ltmp > lim) begin
        ltmp = lim;
      end
      if (ltmp < -lim) begin
        ltmp = -lim;
      end
      s_d.lvl[si] = 16'(ltmp);
    end

    // edge of the chosen direction on the selected comparator
    cur = cmp_now[si];
    prv = s_q.cmp_prev[si];
    fire = s_q.slope_rise[si] ? (cur && !prv) : (!cur && prv);

    // acquisition sequencing
    pre_samp = (s_q.delay < 0) ? 40'(-40'(s_q.delay) * DEPTH / STEPS_PER_RECORD) : '0;
    rem = 40'(40'(DEPTH) + 40'(s_q.delay) * DEPTH / STEPS_PER_RECORD);
    if (ram_we) begin
      s_d.wptr = s_q.wptr + AW'(1);
    end
    case (s_q.acq)
      ST_HOLD: begin
      end
      ST_FILL: begin
        if (ram_we && s_q.fill_cnt != (AW+1)'(DEPTH)) begin
          s_d.fill_cnt = s_q.fill_cnt + (AW+1)'(1);
        end
        if (40'(s_q.fill_cnt) >= pre_samp) begin
          s_d.acq = ST_READY;
        end
      end
      ST_READY: begin
        if (fire) begin
          s_d.acq = ST_POST;
          s_d.trig_addr = s_q.wptr;
          // trigger sample is the first of the record, so count one fewer
          s_d.post_cnt = (rem == '0) ? 34'h0 : 34'(rem - 40'h1);
        end
      end
      ST_POST: begin
        if (ram_we) begin
          s_d.post_cnt = s_q.post_cnt - 34'h1;
          if (s_q.post_cnt <= 34'h1) begin
            s_d.done = 1'b1;
            s_d.trigd = 1'b1;
            s_d.fill_cnt = '0;
            if (s_q.mode == MODE_NORMAL) begin
              s_d.acq = ST_FILL;
            end else if (ris_mode && !ris_done) begin
              s_d.acq = ST_FILL;
              s_d.ris_got = 1'b1;
            end else begin
              s_d.acq = ST_HOLD;
              s_d.partial = 1'b0;
            end
          end
        end
      end
      default: s_d.acq = ST_HOLD;
    endcase

    // mode buttons take priority over the sequencer
    if (btn_rise[12]) begin
      s_d.mode = MODE_NORMAL;
      s_d.frozen = 1'b0;
      if (s_q.acq == ST_HOLD) begin
        s_d.acq = ST_FILL;
        s_d.fill_cnt = '0;
      end
    end else if (btn_rise[11]) begin
      s_d.mode = MODE_SINGLE;
      if (s_q.mode == MODE_NORMAL || (s_q.acq == ST_HOLD && !s_q.frozen)) begin
        s_d.acq = ST_FILL;
        s_d.fill_cnt = '0;
        s_d.trigd = s_d.done; // a record ending now beats the re-arm clear
        s_d.ris_got = 1'b0;
        s_d.partial = 1'b0;
      end else if (s_q.frozen) begin
        s_d.acq = ST_FILL;
        s_d.frozen = 1'b0;
      end else if (roll_mode) begin
        s_d.acq = ST_HOLD;
        s_d.frozen = 1'b1;
      end else if (ris_mode && s_q.ris_got) begin
        s_d.acq = ST_HOLD;
        s_d.partial = 1'b1;
        s_d.done = 1'b1;
        s_d.trigd = 1'b1;
      end else begin
        s_d.acq = ST_HOLD;
        s_d.trigd = 1'b1;
      end
    end

    // no-trigger watchdog, normal mode only; display record is left alone
    if (s_q.mode != MODE_NORMAL || s_q.acq == ST_HOLD || (s_q.acq == ST_READY && fire)) begin
      s_d.notrig_cnt = '0;
      s_d.warn = 1'b0;
    end else if (s_q.notrig_cnt >= 26'(NOTRIG_CYCLES - 1)) begin
      s_d.warn = 1'b1;
    end else begin
      s_d.notrig_cnt = s_q.notrig_cnt + 26'h1;
    end

    // registered outputs
    s_d.coup_out = s_d.coup[si];
    s_d.slope_out = s_d.slope_rise[si];
    s_d.lvl_out = (s_d.src == SRC_LINE) ? 16'h0000 : s_d.lvl[si];
    s_d.pre_pct = (s_d.delay < 0) ? 10'(-s_d.delay * TENTH_PCT_PER_STEP) : 10'h000;
    s_d.post_ps = (s_d.delay > 0) ?
      64'(64'(s_d.delay) * 64'(tdiv_ns) * 64'(PS_PER_STEP_NS)) : 64'h0;
    s_d.ready = (s_d.acq == ST_FILL) || (s_d.acq == ST_READY);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.src <= RST_SRC;
      s_q.coup <= {4{RST_COUP}};
      s_q.slope_rise <= {4{RST_SLOPE_RISE}};
      s_q.mode <= RST_MODE;
      s_q.acq <= RST_ACQ;
      s_q.coup_out <= RST_COUP;
      s_q.slope_out <= RST_SLOPE_RISE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign sel_src = s_q.src;
  assign coupling = s_q.coup_out;
  assign slope_rising = s_q.slope_out;
  assign trig_level = s_q.lvl_out;
  assign ext_note = s_q.ext_note;
  assign adv_led = s_q.adv;
  assign pretrig_tenth_pct = s_q.pre_pct;
  assign post_delay_ps = s_q.post_ps;
  assign ready_led = s_q.ready;
  assign trigd_led = s_q.trigd;
  assign record_done = s_q.done;
  assign trig_addr = s_q.trig_addr;
  assign partial_recon = s_q.partial;
  assign frozen = s_q.frozen;
  assign no_trig_warn = s_q.warn;

endmodule // stt_ctrl

// *** testbench/stt_ctrl_asserts.sv ***
`timescale 1ns/1ps
module stt_ctrl_asserts import stt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched inputs
  input wire logic no_hf_mode,
  input wire logic [15:0] sel_vdiv_mv,
  // watched outputs
  input wire logic [1:0] sel_src,
  input wire logic [2:0] coupling,
  input wire logic slope_rising,
  input wire logic [15:0] trig_level,
  input wire logic ext_note,
  input wire logic [9:0] pretrig_tenth_pct,
  input wire logic [63:0] post_delay_ps,
  input wire logic ready_led,
  input wire logic record_done,
  input wire logic frozen
);
  // ======================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_hf_held;
    (coupling == 3'h0 && $stable(sel_src)) [*2];
  endsequence
  sequence s_no_hf;
    no_hf_mode [*2];
  endsequence
  // only judged on a change: a later gain change may leave it outside
  property p_lvl_clamp;
    $changed(trig_level) && $stable(sel_src) && sel_src < 2'h2 |->
      $signed(trig_level) <= 5 * $signed({1'b0, sel_vdiv_mv}) &&
      $signed(trig_level) >= -5 * $signed({1'b0, sel_vdiv_mv});
  endproperty
  chk_line_level: assert property (sel_src == 2'h3 |-> trig_level == 16'h0000)
    else $error("level not zero on line source");
  chk_hf_slope: assert property (s_hf_held |-> $stable(slope_rising) && slope_rising)
    else $error("slope moved under hf coupling");
  chk_hf_forced: assert property (s_no_hf |-> coupling != 3'h0)
    else $error("hf coupling kept in incompatible mode");
  chk_done_pulse: assert property (record_done |=> !record_done)
    else $error("record done longer than one cycle");
  chk_pre_range: assert property (pretrig_tenth_pct <= 10'h3E8 && !pretrig_tenth_pct[0])
    else $error("pretrigger out of range or odd");
  chk_one_delay: assert property (pretrig_tenth_pct != 10'h000 |-> post_delay_ps == 64'h0)
    else $error("pre and post delay both set");
  chk_roll_frozen: assert property (frozen |-> !ready_led)
    else $error("acquiring while frozen");
  chk_level_clamp: assert property (p_lvl_clamp)
    else $error("channel level past five divisions");
  chk_ext_pulse: assert property (ext_note |=> !ext_note)
    else $error("ext note longer than one cycle");
endmodule // stt_ctrl_asserts

bind stt_ctrl stt_ctrl_asserts u_chk (.clk(clk), .nrst(nrst), .no_hf_mode(no_hf_mode),
  .sel_vdiv_mv(sel_vdiv_mv), .sel_src(sel_src), .coupling(coupling), .slope_rising(slope_rising),
  .trig_level(trig_level), .ext_note(ext_note), .pretrig_tenth_pct(pretrig_tenth_pct),
  .post_delay_ps(post_delay_ps), .ready_led(ready_led), .record_done(record_done), .frozen(frozen));

// *** testbench/stt_trig_model.sv ***
`timescale 1ns/1ps
module stt_trig_model (
  // clock
  input wire logic clk,
  // request from bench
  input wire logic fire,
  input wire logic [1:0] sel,
  // comparator levels
  output logic [2:0] trig_cmp,
  output logic line_zero_cross
);
  // ======================================
  // each request flips one comparator, so edges alternate rise and fall
  initial trig_cmp = 3'h0;
  initial line_zero_cross = 1'b0;
  always @(posedge clk) begin
    if (fire && sel != 2'h3) trig_cmp[sel] <= ~trig_cmp[sel];
    if (fire && sel == 2'h3) line_zero_cross <= ~line_zero_cross;
  end
endmodule // stt_trig_model

// *** testbench/stt_ctrl_test.sv ***
`timescale 1ns/1ps
module stt_ctrl_test import stt_pkg::*;;
  // ======================================
  // stimulus and observation
  logic clk = 1'b0, nrst = 1'b0, fire = 1'b0, ext_fitted = 1'b0, no_hf_mode = 1'b0;
  logic ris_mode = 1'b0, roll_mode = 1'b0, seen_ext = 1'b0, dly_dir = 1'b0, got;
  logic [15:0] btn = 16'h0000, vdiv = 16'h0002;
  logic [7:0] adc = 8'h00;
  logic [2:0] cmp, coupling;
  logic lzc, slope_rising, ext_note, adv_led, ready_led, trigd_led, record_done;
  logic partial_recon, frozen, no_trig_warn;
  logic [1:0] sel_src;
  logic [15:0] trig_level;
  logic [9:0] pretrig_tenth_pct;
  logic [63:0] post_delay_ps;
  logic ris_done = 1'b0, lvl_dir = 1'b1;
  logic [1:0] tsel = 2'h1;
  logic [3:0] rd_addr = 4'h0, trig_addr, ta;
  logic [7:0] rd_data, first;
  int fail_count = 0, check_count = 0, cyc = 0;

  always #25 clk = ~clk;
  always @(negedge clk) adc <= adc + 8'h01;
  always @(negedge clk) if (ext_note === 1'b1) seen_ext <= 1'b1;

  stt_trig_model MODEL (.clk, .fire, .sel(tsel), .trig_cmp(cmp), .line_zero_cross(lzc));
  // short counts keep the run small; depth is 16 samples
  stt_ctrl #(.AW(4), .NOTRIG_CYCLES(50), .KNOB_FAST_CYCLES(8)) DUT (.clk, .nrst,
    .src_btn(btn[3:0]), .coup_btn(btn[8:4]), .slope_btn(btn[9]), .zero_btn(btn[10]),
    .single_btn(btn[11]), .norm_btn(btn[12]), .adv_btn(btn[13]), .dly_knob_step(btn[14]),
    .dly_knob_dir(dly_dir), .lvl_knob_step(btn[15]), .lvl_knob_dir(lvl_dir), .ext_fitted,
    .trig_cmp(cmp), .line_zero_cross(lzc), .no_hf_mode, .ris_mode, .roll_mode, .ris_done,
    .tdiv_ns(32'h0000_0064), .sel_vdiv_mv(vdiv), .adc_valid(1'b1), .adc_data(adc), .rd_addr,
    .sel_src, .coupling, .slope_rising, .trig_level, .ext_note, .adv_led, .pretrig_tenth_pct,
    .post_delay_ps, .ready_led, .trigd_led, .record_done, .trig_addr, .partial_recon, .frozen,
    .no_trig_warn, .rd_data);

  // ======================================
  // helpers
  task chk(input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // eight cycles a press: long enough for sync, short of the knob fast gap
  task push(input int k);
    @(negedge clk) btn[k] = 1'b1;
    repeat (3) @(negedge clk);
    btn[k] = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task shot(input int n);
    got = 1'b0;
    @(negedge clk) fire = 1'b1;
    @(negedge clk) fire = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (record_done === 1'b1) got = 1'b1;
    end
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ======================================
  // scenarios
  task t_reset;
    chk(sel_src, 2'h0);
    chk(coupling, 3'h4);
    chk({slope_rising, trig_level, pretrig_tenth_pct}, 27'h4000000);
    chk({no_trig_warn, frozen, partial_recon, trigd_led}, 4'h0);
  endtask
  task t_coupling;
    for (int s = 0; s < 4; s++) begin
      push(s);
      push(5 + s);
    end
    for (int s = 0; s < 4; s++) begin
      push(s);
      chk(sel_src, s[1:0]);
      chk(coupling, s[2:0] + 3'h1);
    end
  endtask
  task t_slope;
    push(0);
    push(4);
    chk(coupling, 3'h0);
    push(9);
    chk(slope_rising, 1'b1);
    no_hf_mode = 1'b1;
    repeat (3) @(negedge clk);
    no_hf_mode = 1'b0;
    chk(coupling, 3'h4);
    push(9);
    chk(slope_rising, 1'b0);
    push(1);
    chk(slope_rising, 1'b1);
    push(0);
    chk(slope_rising, 1'b0);
  endtask
  task t_level;
    push(1);
    repeat (12) push(15);
    chk(trig_level, 16'h000A);
    vdiv = 16'h0001;
    repeat (2) @(negedge clk);
    chk(trig_level, 16'h000A);
    push(3);
    push(15);
    chk(trig_level, 16'h0000);
    push(1);
    chk(trig_level, 16'h000A);
    lvl_dir = 1'b0;
    push(15);
    chk(trig_level, 16'h0005);
    lvl_dir = 1'b1;
  endtask
  task t_delay;
    push(14);
    chk(pretrig_tenth_pct, 10'h002);
    push(14);
    chk(pretrig_tenth_pct, 10'h034);
    push(10);
    chk(pretrig_tenth_pct, 10'h000);
    repeat (21) push(14);
    chk(pretrig_tenth_pct, 10'h3E8);
    push(10);
    dly_dir = 1'b1;
    repeat (10) @(negedge clk);
    push(14);
    chk(post_delay_ps, 64'h7D0);
    push(0);
    chk({pretrig_tenth_pct, post_delay_ps[15:0]}, 26'h7D0);
    push(1);
    push(10);
    chk(post_delay_ps, 64'h0);
  endtask
  task t_modes;
    shot(40);
    chk({got, trigd_led, ready_led}, 3'h7);
    ta = trig_addr;
    shot(60);
    chk({got, no_trig_warn}, 2'h1);
    chk(trig_addr, ta);
    shot(40);
    chk({got, no_trig_warn}, 2'h2);
    push(11);
    shot(10);
    shot(40);
    chk({got, ready_led}, 2'h2);
    // held record: trigger sample at trig_addr, last of the record just below it
    rd_addr = trig_addr;
    repeat (2) @(negedge clk);
    first = rd_data;
    rd_addr = trig_addr - 4'h1;
    repeat (2) @(negedge clk);
    chk(8'(rd_data - first), 8'h0F);
    shot(10);
    shot(40);
    chk(got, 1'b0);
    push(11);
    chk({trigd_led, ready_led}, 2'h1);
    push(11);
    chk({trigd_led, ready_led}, 2'h2);
  endtask
  task t_roll_ris;
    push(11);
    roll_mode = 1'b1;
    push(11);
    chk({frozen, ready_led}, 2'h2);
    push(11);
    chk({frozen, ready_led}, 2'h1);
    roll_mode = 1'b0;
    ris_mode = 1'b1;
    shot(10);
    shot(40);
    chk({got, ready_led}, 2'h3);
    push(11);
    chk({partial_recon, ready_led}, 2'h2);
    ris_done = 1'b1;
    push(11);
    shot(10);
    shot(40);
    chk({got, ready_led, partial_recon}, 3'h4);
    ris_done = 1'b0;
    ris_mode = 1'b0;
    push(12);
    chk(ready_led, 1'b1);
    push(3);
    tsel = 2'h3;
    shot(40);
    chk(got, 1'b1);
    tsel = 2'h1;
    push(1);
    push(13);
    chk(adv_led, 1'b1);
    push(13);
    chk(adv_led, 1'b0);
  endtask
  task t_ext;
    nrst = 1'b0;
    ext_fitted = 1'b1;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    push(2);
    chk(seen_ext, 1'b1);
    repeat (205) push(15);
    chk(trig_level, 16'h00C8);
  endtask

  // ======================================
  // main sequence and hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out;
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    t_reset;
    t_coupling;
    t_slope;
    t_level;
    t_delay;
    t_modes;
    t_roll_ris;
    t_ext;
    close_out;
  end
endmodule // stt_ctrl_test
